// ==== logic/pbi_pkg.sv ====
// Overview of operation
// - send ring wraps at base plus length, flags full
// - continuous send bit keeps transmit state
// - continuous receive bit keeps receive state
// - calibration stores band result, readable and writable
// - calibration stores amplitude result, readable and writable
// - status reports delimiter bit1, preamble bit0
// - assess irq: timer expiry, infinity only clear
// - timer mode exposes busy or clear result
// - full source bit6 from either ring
// - almost-full source bit5 from either threshold
// - receive end-of-frame source bit4
// - transmit end-of-frame source bit3
// - checksum-good source bit2
// - header irq armed by delimiter, issued after header
// - preamble-detect source bit0
// - mask bit one enables matching source
// - receive ring wraps at base plus length, flags full
// - send almost-full at base plus threshold
package pbi_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_RX_STATUS   = 10'h01F;
    localparam logic [9:0] IDX_IRQ_MASK    = 10'h100;
    localparam logic [9:0] IDX_RX_ALMOST   = 10'h134;
    localparam logic [9:0] IDX_RX_LEN      = 10'h135;
    localparam logic [9:0] IDX_TX_ALMOST   = 10'h136;
    localparam logic [9:0] IDX_TX_LEN      = 10'h137;
    localparam logic [9:0] IDX_RSVD_A      = 10'h138;
    localparam logic [9:0] IDX_TEST        = 10'h139;
    localparam logic [9:0] IDX_RSVD_B      = 10'h13A;
    localparam logic [9:0] IDX_BAND        = 10'h13B;
    localparam logic [9:0] IDX_AMPL        = 10'h13C;
    localparam logic [9:0] IDX_IRQ_FLAGS   = 10'h336;
    localparam logic [9:0] IDX_TX_BASE     = 10'h3F0;
    localparam logic [9:0] IDX_RX_BASE     = 10'h3F1;
    localparam logic [9:0] IDX_ASSESS_CTRL = 10'h3F2;
    localparam logic [9:0] IDX_ASSESS_STAT = 10'h3F3;

    // field positions
    localparam int unsigned IRQ_ASSESS   = 7;
    localparam int unsigned IRQ_FULL     = 6;
    localparam int unsigned IRQ_ALMOST   = 5;
    localparam int unsigned IRQ_RX_EOF   = 4;
    localparam int unsigned IRQ_TX_EOF   = 3;
    localparam int unsigned IRQ_CRC_OK   = 2;
    localparam int unsigned IRQ_HEADER   = 1;
    localparam int unsigned IRQ_PREAMBLE = 0;
    localparam int unsigned TEST_CONT_RX = 0;
    localparam int unsigned TEST_CONT_TX = 1;
    localparam int unsigned STAT_SFD     = 1;
    localparam int unsigned STAT_PRE     = 0;
    localparam int unsigned ASSESS_INF   = 0;

    // values after reset and fixed read values
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] RSVD_B_VAL = 8'h01;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;

    typedef enum logic [1:0] {
        idle_on_state,
        transmit_state,
        receive_assess_state
    } pbi_state_t;

endpackage : pbi_pkg

// ==== logic/pbi_regs.sv ====
// Chosen here: the APB interface to the registers.
module pbi_regs #(
    parameter int unsigned ADDR_W = 12,
    parameter int unsigned PTR_W  = 9
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [ADDR_W-1:0]      paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   start_send,
    input  wire logic                   start_receive,
    input  wire logic                   go_idle,
    input  wire logic                   send_byte_done,
    input  wire logic                   send_packet_done,
    input  wire logic                   recv_byte_written,
    input  wire logic                   recv_packet_done,
    input  wire logic                   preamble_seen,
    input  wire logic                   sfd_seen,
    input  wire logic                   phr_done,
    input  wire logic                   crc_good,
    input  wire logic                   assess_done,
    input  wire logic                   assess_clear,
    input  wire logic                   cal_done,
    input  wire logic [7:0]             cal_band,
    input  wire logic [7:0]             cal_amplitude,
    output pbi_pkg::pbi_state_t         radio_state,
    output logic      [PTR_W-1:0]       send_read_ptr,
    output logic      [PTR_W-1:0]       recv_write_ptr,
    output logic      [7:0]             osc_band_cal_result,
    output logic      [7:0]             osc_amplitude_cal_result,
    output logic                        channel_assess_result,
    output logic                        irq
);
    import pbi_pkg::*;

    // the index field needs paddr[11:2]; ring sums need nine bits
    if (ADDR_W < 12) begin : g_chk_addr
        $error("pbi_regs: ADDR_W must be at least 12");
    end
    if (PTR_W < 9) begin : g_chk_ptr
        $error("pbi_regs: PTR_W must be at least 9");
    end

    logic [9:0]  idx;
    logic        setup_ph;
    logic        access_ph;
    logic        wr_en;
    logic [7:0]  wbyte;
    logic [7:0]  rd_mux;

    logic [7:0]  interrupt_enable_mask;
    logic [7:0]  interrupt_pending_flags;
    logic [7:0]  send_ring_length;
    logic [7:0]  send_almost_level;
    logic [7:0]  receive_ring_length;
    logic [7:0]  receive_almost_level;
    logic [7:0]  send_ring_base;
    logic [7:0]  receive_ring_base;
    logic [1:0]  continuous_test_control;
    logic        assess_infinity;
    logic        frame_delimiter_seen;
    logic        preamble_detected;
    logic        header_pending;

    logic [7:0]  tx_off;
    logic [7:0]  rx_off;
    logic [7:0]  next_tx_off;
    logic [7:0]  next_rx_off;
    logic        tx_step;
    logic        rx_step;
    logic        tx_start;
    logic        rx_start;
    logic        tx_full;
    logic        rx_full;
    logic        tx_almost;
    logic        rx_almost;
    logic [7:0]  events;
    logic [7:0]  flag_clr;

    // whether a word index names a mapped register
    function automatic logic reg_known(input logic [9:0] i);
        logic k;
        k = 1'b0;
        if (i == IDX_RX_STATUS) k = 1'b1;
        else if (i == IDX_IRQ_MASK) k = 1'b1;
        else if (i >= IDX_RX_ALMOST && i <= IDX_AMPL) k = 1'b1;
        else if (i == IDX_IRQ_FLAGS) k = 1'b1;
        else if (i >= IDX_TX_BASE && i <= IDX_ASSESS_STAT) k = 1'b1;
        return k;
    endfunction : reg_known

    // ring address in packet memory, base plus offset
    function automatic logic [PTR_W-1:0] ring_addr(
        input logic [7:0] base,
        input logic [7:0] off
    );
        logic [8:0] s;
        s = {1'b0, base} + {1'b0, off};
        return PTR_W'(s);
    endfunction : ring_addr

    // apb decode: no wait states, lane 0 carries the byte
    assign idx       = paddr[11:2];
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_en     = access_ph & pwrite & pstrb[0] & reg_known(idx);
    assign wbyte     = pwdata[7:0];
    assign pready    = 1'b1;
    assign pslverr   = access_ph & ~reg_known(idx);

    // read mux; reserved and unmapped locations read as fixed values
    always_comb begin
        rd_mux = ZERO_BYTE;
        if (idx == IDX_RX_STATUS) begin
            rd_mux[STAT_SFD] = frame_delimiter_seen;
            rd_mux[STAT_PRE] = preamble_detected;
        end else if (idx == IDX_IRQ_MASK) begin
            rd_mux = interrupt_enable_mask;
        end else if (idx == IDX_RX_ALMOST) begin
            rd_mux = receive_almost_level;
        end else if (idx == IDX_RX_LEN) begin
            rd_mux = receive_ring_length;
        end else if (idx == IDX_TX_ALMOST) begin
            rd_mux = send_almost_level;
        end else if (idx == IDX_TX_LEN) begin
            rd_mux = send_ring_length;
        end else if (idx == IDX_TEST) begin
            rd_mux[1:0] = continuous_test_control;
        end else if (idx == IDX_RSVD_B) begin
            rd_mux = RSVD_B_VAL;
        end else if (idx == IDX_BAND) begin
            rd_mux = osc_band_cal_result;
        end else if (idx == IDX_AMPL) begin
            rd_mux = osc_amplitude_cal_result;
        end else if (idx == IDX_IRQ_FLAGS) begin
            rd_mux = interrupt_pending_flags;
        end else if (idx == IDX_TX_BASE) begin
            rd_mux = send_ring_base;
        end else if (idx == IDX_RX_BASE) begin
            rd_mux = receive_ring_base;
        end else if (idx == IDX_ASSESS_CTRL) begin
            rd_mux[ASSESS_INF] = assess_infinity;
        end else if (idx == IDX_ASSESS_STAT) begin
            rd_mux[0]   = channel_assess_result;
            rd_mux[2:1] = radio_state;
        end
    end

    // read data is captured in the setup phase so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata <= {24'h00_0000, rd_mux};
        end
    end

    // plain software-owned configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_enable_mask   <= RST_BYTE;
            send_ring_length        <= RST_BYTE;
            send_almost_level       <= RST_BYTE;
            receive_ring_length     <= RST_BYTE;
            receive_almost_level    <= RST_BYTE;
            send_ring_base          <= RST_BYTE;
            receive_ring_base       <= RST_BYTE;
            continuous_test_control <= 2'b00;
            assess_infinity         <= 1'b0;
        end else if (wr_en) begin
            if (idx == IDX_IRQ_MASK) begin
                interrupt_enable_mask <= wbyte;
            end else if (idx == IDX_TX_LEN) begin
                // values of two or less are the host's fault
                send_ring_length <= wbyte;
            end else if (idx == IDX_TX_ALMOST) begin
                send_almost_level <= wbyte;
            end else if (idx == IDX_RX_LEN) begin
                receive_ring_length <= wbyte;
            end else if (idx == IDX_RX_ALMOST) begin
                receive_almost_level <= wbyte;
            end else if (idx == IDX_TX_BASE) begin
                send_ring_base <= wbyte;
            end else if (idx == IDX_RX_BASE) begin
                receive_ring_base <= wbyte;
            end else if (idx == IDX_TEST) begin
                continuous_test_control <= wbyte[1:0];
            end else if (idx == IDX_ASSESS_CTRL) begin
                assess_infinity <= wbyte[ASSESS_INF];
            end
        end
    end

    // calibration results; a finished calibration beats a bus write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_band_cal_result      <= RST_BYTE;
            osc_amplitude_cal_result <= RST_BYTE;
        end else if (cal_done) begin
            osc_band_cal_result      <= cal_band;
            osc_amplitude_cal_result <= cal_amplitude;
        end else if (wr_en) begin
            if (idx == IDX_BAND) begin
                osc_band_cal_result <= wbyte;
            end else if (idx == IDX_AMPL) begin
                osc_amplitude_cal_result <= wbyte;
            end
        end
    end

    // radio state sequencing
    assign tx_start = (radio_state == idle_on_state) & start_send;
    assign rx_start = (radio_state == idle_on_state) & ~start_send
                      & start_receive;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            radio_state <= idle_on_state;
        end else begin
            case (radio_state)
                idle_on_state: begin
                    if (tx_start) begin
                        radio_state <= transmit_state;
                    end else if (rx_start) begin
                        radio_state <= receive_assess_state;
                    end
                end
                transmit_state: begin
                    if (go_idle) begin
                        radio_state <= idle_on_state;
                    end else if (send_packet_done
                                 && !continuous_test_control[TEST_CONT_TX])
                    begin
                        radio_state <= idle_on_state;
                    end
                end
                receive_assess_state: begin
                    if (go_idle) begin
                        radio_state <= idle_on_state;
                    end else if (recv_packet_done
                                 && !continuous_test_control[TEST_CONT_RX])
                    begin
                        radio_state <= idle_on_state;
                    end
                end
                default: begin
                    radio_state <= idle_on_state;
                end
            endcase
        end
    end

    // ring offsets; compare before stepping so the last byte is base+len
    assign tx_step   = send_byte_done & (radio_state == transmit_state);
    assign rx_step   = recv_byte_written
                       & (radio_state == receive_assess_state);
    assign tx_full   = tx_step & (tx_off == send_ring_length);
    assign rx_full   = rx_step & (rx_off == receive_ring_length);
    assign tx_almost = tx_step & (tx_off == send_almost_level);
    assign rx_almost = rx_step & (rx_off == receive_almost_level);

    always_comb begin
        next_tx_off = tx_off;
        if (tx_start) begin
            next_tx_off = ZERO_BYTE;
        end else if (tx_full) begin
            next_tx_off = ZERO_BYTE;
        end else if (tx_step) begin
            next_tx_off = tx_off + 8'h01;
        end
    end

    always_comb begin
        next_rx_off = rx_off;
        if (rx_start) begin
            next_rx_off = ZERO_BYTE;
        end else if (rx_full) begin
            next_rx_off = ZERO_BYTE;
        end else if (rx_step) begin
            next_rx_off = rx_off + 8'h01;
        end
    end

    // pointers registered so the memory sees a clean address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_off         <= RST_BYTE;
            rx_off         <= RST_BYTE;
            send_read_ptr  <= '0;
            recv_write_ptr <= '0;
        end else begin
            tx_off         <= next_tx_off;
            rx_off         <= next_rx_off;
            send_read_ptr  <= ring_addr(send_ring_base, next_tx_off);
            recv_write_ptr <= ring_addr(receive_ring_base, next_rx_off);
        end
    end

    // detection status, cleared when a new reception starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_delimiter_seen <= 1'b0;
            preamble_detected    <= 1'b0;
        end else begin
            if (sfd_seen) begin
                frame_delimiter_seen <= 1'b1;
            end else if (rx_start) begin
                frame_delimiter_seen <= 1'b0;
            end
            if (preamble_seen) begin
                preamble_detected <= 1'b1;
            end else if (rx_start) begin
                preamble_detected <= 1'b0;
            end
        end
    end

    // header irq is armed by the delimiter and fired at header end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            header_pending <= 1'b0;
        end else if (sfd_seen) begin
            header_pending <= 1'b1;
        end else if (phr_done || radio_state == idle_on_state) begin
            header_pending <= 1'b0;
        end
    end

    // assessment outcome latched each time a period ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_assess_result <= 1'b0;
        end else if (assess_done) begin
            channel_assess_result <= assess_clear;
        end
    end

    // event sources, one bit per pending flag
    always_comb begin
        events = ZERO_BYTE;
        events[IRQ_ASSESS]   = assess_done
                               & (~assess_infinity | assess_clear);
        events[IRQ_FULL]     = tx_full | rx_full;
        events[IRQ_ALMOST]   = tx_almost | rx_almost;
        events[IRQ_RX_EOF]   = recv_packet_done
                               & (radio_state == receive_assess_state);
        events[IRQ_TX_EOF]   = send_packet_done
                               & (radio_state == transmit_state);
        events[IRQ_CRC_OK]   = crc_good;
        events[IRQ_HEADER]   = phr_done & header_pending;
        events[IRQ_PREAMBLE] = preamble_seen;
    end

    // write one to clear; a new event in the same cycle wins
    assign flag_clr = (wr_en && idx == IDX_IRQ_FLAGS) ? wbyte : ZERO_BYTE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_pending_flags <= RST_BYTE;
        end else begin
            // one expression, so the flags keep a single driver
            interrupt_pending_flags <= (interrupt_pending_flags & ~flag_clr)
                                       | events;
        end
    end

    // single level interrupt, gated per source by the mask
    assign irq = |(interrupt_pending_flags & interrupt_enable_mask);

endmodule : pbi_regs

// ==== sim/packet_buffer_irq_regs_tb.sv ====
module packet_buffer_irq_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pbi_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        assess_clear, car, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [12:0] evt;
    logic [7:0]  cal_band, cal_amp, band, amp;
    logic [8:0]  tx_ptr, rx_ptr;
    pbi_state_t  state;
    int          fail_count, n_checks, cycles;

    // evt bits: 0 start send, 1 start receive, 2 idle, 3 byte sent,
    // 4 packet sent, 5 byte written, 6 packet received, 7 preamble,
    // 8 delimiter, 9 header done, 10 crc good, 11 assess done, 12 cal done
    pbi_regs uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .start_send(evt[0]), .start_receive(evt[1]), .go_idle(evt[2]),
        .send_byte_done(evt[3]), .send_packet_done(evt[4]),
        .recv_byte_written(evt[5]), .recv_packet_done(evt[6]),
        .preamble_seen(evt[7]), .sfd_seen(evt[8]), .phr_done(evt[9]),
        .crc_good(evt[10]), .assess_done(evt[11]),
        .assess_clear(assess_clear), .cal_done(evt[12]),
        .cal_band(cal_band), .cal_amplitude(cal_amp),
        .radio_state(state), .send_read_ptr(tx_ptr),
        .recv_write_ptr(rx_ptr), .osc_band_cal_result(band),
        .osc_amplitude_cal_result(amp), .channel_assess_result(car),
        .irq(irq)
    );

    // free-running clock, 40 ns period
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer; an idle edge first keeps drivers single per step
    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        pstrb <= 4'hF;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [9:0] idx, input logic [7:0] e,
                         input string what);
        apb(1'b0, idx, 8'h00);
        chk(what, rd, {24'h0, e});
    endtask : rdchk

    // one-cycle event pulse; outputs are read at the following negedge
    task automatic ev(input int i, input logic c = 1'b0);
        @(posedge pclk);
        evt <= 13'(1) << i;
        assess_clear <= c;
        @(posedge pclk);
        evt <= '0;
        @(negedge pclk);
    endtask : ev

    task automatic t_regs;
        rdchk(IDX_IRQ_FLAGS, 8'h00, "flags reset");
        rdchk(IDX_RSVD_A, 8'h00, "reserved a");
        rdchk(IDX_RSVD_B, 8'h01, "reserved b");
        apb(1'b1, IDX_RX_STATUS, 8'hFF);
        rdchk(IDX_RX_STATUS, 8'h00, "status read only");
        apb(1'b1, IDX_IRQ_MASK, 8'hA5);
        rdchk(IDX_IRQ_MASK, 8'hA5, "mask");
        apb(1'b0, 10'h200, 8'h00);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
    endtask : t_regs

    task automatic t_send;
        apb(1'b1, IDX_IRQ_MASK, 8'h00);
        apb(1'b1, IDX_TX_BASE, 8'h10);
        apb(1'b1, IDX_TX_LEN, 8'h04);
        apb(1'b1, IDX_TX_ALMOST, 8'h03);
        apb(1'b1, IDX_TEST, 8'h00);
        ev(0);
        chk("send ptr start", tx_ptr, 32'h10);
        repeat (4) ev(3);
        chk("send ptr", tx_ptr, 32'h14);
        rdchk(IDX_IRQ_FLAGS, 8'h20, "send almost");
        ev(3);
        chk("send wrap", tx_ptr, 32'h10);
        rdchk(IDX_IRQ_FLAGS, 8'h60, "send full");
        ev(4);
        chk("send to idle", state, idle_on_state);
        rdchk(IDX_IRQ_FLAGS, 8'h68, "send eof");
        apb(1'b1, IDX_TEST, 8'h02);
        ev(0);
        ev(4);
        chk("send holds", state, transmit_state);
        rdchk(IDX_ASSESS_STAT, 8'h02, "state read");
        ev(2);
    endtask : t_send

    task automatic t_recv;
        apb(1'b1, IDX_IRQ_FLAGS, 8'hFF);
        rdchk(IDX_IRQ_FLAGS, 8'h00, "write one clears");
        apb(1'b1, IDX_RX_BASE, 8'h20);
        apb(1'b1, IDX_RX_LEN, 8'h04);
        apb(1'b1, IDX_RX_ALMOST, 8'h03);
        apb(1'b1, IDX_TEST, 8'h00);
        ev(1);
        chk("recv state", state, receive_assess_state);
        ev(7);
        ev(8);
        rdchk(IDX_RX_STATUS, 8'h03, "detect status");
        rdchk(IDX_IRQ_FLAGS, 8'h01, "header held");
        ev(9);
        ev(10);
        rdchk(IDX_IRQ_FLAGS, 8'h07, "header crc");
        repeat (5) ev(5);
        chk("recv wrap", rx_ptr, 32'h20);
        ev(6);
        chk("recv to idle", state, idle_on_state);
        rdchk(IDX_IRQ_FLAGS, 8'h77, "recv flags");
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, IDX_TEST, 8'h01);
        ev(1);
        ev(6);
        chk("recv holds", state, receive_assess_state);
        ev(2);
    endtask : t_recv

    task automatic t_assess;
        apb(1'b1, IDX_IRQ_FLAGS, 8'hFF);
        apb(1'b1, IDX_ASSESS_CTRL, 8'h00);
        ev(11, 1'b0);
        chk("assess busy", {31'h0, car}, 32'h0);
        rdchk(IDX_IRQ_FLAGS, 8'h80, "timer busy");
        apb(1'b1, IDX_IRQ_FLAGS, 8'hFF);
        ev(11, 1'b1);
        chk("assess clear", {31'h0, car}, 32'h1);
        apb(1'b1, IDX_IRQ_FLAGS, 8'hFF);
        apb(1'b1, IDX_ASSESS_CTRL, 8'h01);
        ev(11, 1'b0);
        rdchk(IDX_IRQ_FLAGS, 8'h00, "infinity busy");
        ev(11, 1'b1);
        rdchk(IDX_IRQ_FLAGS, 8'h80, "infinity clear");
    endtask : t_assess

    task automatic t_irq;
        apb(1'b1, IDX_IRQ_MASK, 8'h7F);
        @(negedge pclk);
        chk("irq other mask", {31'h0, irq}, 32'h0);
        apb(1'b1, IDX_IRQ_MASK, 8'h80);
        @(negedge pclk);
        chk("irq enabled", {31'h0, irq}, 32'h1);
        repeat (20) @(posedge pclk);
        rdchk(IDX_IRQ_FLAGS, 8'h80, "flag sticky");
        apb(1'b1, IDX_IRQ_FLAGS, 8'h80);
        @(negedge pclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
    endtask : t_irq

    task automatic t_cal;
        @(posedge pclk);
        cal_band <= 8'h5A;
        cal_amp <= 8'hC3;
        ev(12);
        chk("band out", band, 32'h5A);
        chk("ampl out", amp, 32'hC3);
        rdchk(IDX_BAND, 8'h5A, "band reg");
        apb(1'b1, IDX_AMPL, 8'h22);
        rdchk(IDX_AMPL, 8'h22, "ampl written");
    endtask : t_cal

    // main sequence: reset for 16 cycles, then each scenario in turn
    initial begin
        {presetn, psel, penable, pwrite, assess_clear} = '0;
        {paddr, pwdata, pstrb, evt, cal_band, cal_amp} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_send();
        t_recv();
        t_assess();
        t_irq();
        t_cal();
        stop_test();
    end
endmodule : packet_buffer_irq_regs_tb

// ==== sim/pbi_checker_assertions.sv ====
module pbi_checker
    import pbi_pkg::*;
#(
    parameter int unsigned PTR_W = 9
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic             start_send,
    input wire logic             start_receive,
    input wire logic             go_idle,
    input wire logic             send_byte_done,
    input wire logic             send_packet_done,
    input wire logic             assess_done,
    input wire logic             assess_clear,
    input wire logic             cal_done,
    input wire logic [7:0]       cal_band,
    input wire logic [7:0]       cal_amplitude,
    input pbi_state_t            radio_state,
    input wire logic [PTR_W-1:0] send_read_ptr,
    input wire logic [7:0]       osc_band_cal_result,
    input wire logic [7:0]       osc_amplitude_cal_result,
    input wire logic             channel_assess_result
);
    // single domain, so one clock and one reset serve every property
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // bus answers: no wait states, errors only in the access phase
    a_ready_now: assert property (pready)
        else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    a_rdata_upper: assert property (prdata[31:8] == 24'h0)
        else $error("prdata upper bits not zero");

    // calibration and assessment results captured with their pulse
    a_band_store: assert property (
        cal_done |=> osc_band_cal_result == $past(cal_band))
        else $error("band result not stored");
    a_ampl_store: assert property (
        cal_done |=> osc_amplitude_cal_result == $past(cal_amplitude))
        else $error("amplitude result not stored");
    a_assess_flag: assert property (
        assess_done |=> channel_assess_result == $past(assess_clear))
        else $error("assess result not captured");

    // state moves out of idle and holds while nothing ends it
    a_send_enter: assert property (
        radio_state == idle_on_state && start_send
        |=> radio_state == transmit_state)
        else $error("no transmit entry");
    a_recv_enter: assert property (
        radio_state == idle_on_state && start_receive && !start_send
        |=> radio_state == receive_assess_state)
        else $error("no receive entry");
    a_send_holds: assert property (
        radio_state == transmit_state && !go_idle && !send_packet_done
        |=> radio_state == transmit_state)
        else $error("transmit state left early");
    a_send_step: assert property (
        radio_state == transmit_state && send_byte_done && !go_idle
        |=> send_read_ptr != $past(send_read_ptr))
        else $error("send pointer did not move");

    c_send_byte: cover property (radio_state == transmit_state
                                 && send_byte_done);
    c_assess_clear: cover property (assess_done && assess_clear);
    c_cal: cover property (cal_done);
    c_bus_err: cover property (pslverr);
endmodule : pbi_checker

bind pbi_regs pbi_checker #(.PTR_W(PTR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_send(start_send), .start_receive(start_receive),
    .go_idle(go_idle), .send_byte_done(send_byte_done),
    .send_packet_done(send_packet_done), .assess_done(assess_done),
    .assess_clear(assess_clear), .cal_done(cal_done),
    .cal_band(cal_band), .cal_amplitude(cal_amplitude),
    .radio_state(radio_state), .send_read_ptr(send_read_ptr),
    .osc_band_cal_result(osc_band_cal_result),
    .osc_amplitude_cal_result(osc_amplitude_cal_result),
    .channel_assess_result(channel_assess_result)
);
